//--- core/spdes_serial_access.sv
// serial two-wire slave of the presence-detect store
`timescale 1ns/1ps
`default_nettype none
module spdes_serial_access #(
	parameter bit LARGE_VARIANT = 1'b0,
	parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] MAKER_CONT = 8'hA5, // arbitrary value
	parameter logic [7:0] BUILD_LOC = 8'h01,
	parameter logic [143:0] PART_NUMBER = "PRESENCE-DETECT-01",
	parameter logic [7:0] PCB_ID = 8'h01,
	parameter logic [7:0] BUILD_YEAR = 8'h00,
	parameter logic [7:0] BUILD_WEEK = 8'h01,
	parameter logic [31:0] SERIAL_NUM = 32'h00000000,
	parameter int unsigned WRC_CYCLES = spdes_pkg::WRC_CYCLES_DEF
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// two-wire bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// straps and status
	input wire logic [spdes_pkg::SEL_BITS-1:0] i_chip_sel,
	input wire logic i_write_control_pin,
	output logic o_write_busy
);
	import spdes_pkg::*;

	// ************************************************************
	// default map
	// ************************************************************
	localparam int CW = $clog2(WRC_CYCLES + 1);
	// power-on content of one byte
	function automatic logic [7:0] spd_default(input logic [7:0] idx);
		logic [7:0] v;
		int k;
		v = 8'h00;
		k = 0;
		if (idx <= OFS_CHECKSUM_LOW_BYTES) v = HDR_BYTES[idx[5:0]];
		if (LARGE_VARIANT) begin
			if (idx == OFS_ROW_ADDRESS_BITS) v = ROW_BITS_LARGE;
			if (idx == OFS_REFRESH_RATE_TYPE) v = REFRESH_LARGE;
			if (idx == OFS_RANK_DENSITY) v = DENSITY_LARGE;
			if (idx == OFS_CHECKSUM_LOW_BYTES) v = CHECKSUM_LARGE;
		end
		if (idx == OFS_MAKER_CODE) v = MAKER_ID;
		if (idx >= OFS_MAKER_CONT_FIRST && idx <= OFS_MAKER_CONT_LAST) v = MAKER_CONT;
		if (idx == OFS_BUILD_LOCATION) v = BUILD_LOC;
		k = int'(idx) - int'(OFS_PART_FIRST);
		if (k >= 0 && k < int'(PART_LEN)) v = PART_NUMBER[(int'(PART_LEN) - 1 - k) * 8 +: 8];
		if (idx == OFS_PCB_ID) v = PCB_ID;
		if (idx == OFS_BUILD_YEAR_BCD) v = BUILD_YEAR;
		if (idx == OFS_BUILD_WEEK_BCD) v = BUILD_WEEK;
		k = int'(idx) - int'(OFS_SERIAL_FIRST);
		if (k >= 0 && k < int'(SERIAL_LEN)) v = SERIAL_NUM[(int'(SERIAL_LEN) - 1 - k) * 8 +: 8];
		return v;
	endfunction

	// ************************************************************
	// declarations
	// ************************************************************
	logic scl_q_ff, sda_q_ff;
	spdes_state_t state_ff, after_ff, nxt_after;
	logic [2:0] bit_cnt_ff;
	logic [7:0] shreg_ff, rx_byte, addr_ff;
	logic ack_ff, nine_ff, sda_oe_ff, sda_out_ff, rd_mode_ff;
	logic nxt_ack, dev_read, dev_match;
	logic busy_ff;
	logic [CW-1:0] wrc_cnt_ff;
	logic [3:0] page_base_ff;
	logic [7:0] page_data_ff [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] page_mask_ff;
	logic [7:0] mem_ff [MEM_BYTES];
	spdes_rd_t fifo_ff [2];
	spdes_rd_t fifo_in;
	logic [1:0] fifo_cnt_ff;
	logic fifo_push, fifo_pop, fifo_flush;
	logic [7:0] tx_byte;
	logic scl_rise, scl_fall, start_det, stop_det, bus_evt;
	logic byte_done, adr_take, wr_take, load_tx, commit;

	// ************************************************************
	// bus event decode
	// ************************************************************
	// inputs already synchronous; one stage gives edges
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end else begin
			scl_q_ff <= i_scl;
			sda_q_ff <= i_sda;
		end
	end

	// start and stop only while the clock line stays high
	assign scl_rise = i_scl & ~scl_q_ff;
	assign scl_fall = ~i_scl & scl_q_ff;
	assign start_det = i_scl & scl_q_ff & sda_q_ff & ~i_sda;
	assign stop_det = i_scl & scl_q_ff & ~sda_q_ff & i_sda;
	assign bus_evt = busy_ff | start_det | stop_det;
	assign rx_byte = {shreg_ff[6:0], i_sda};
	assign byte_done = ~bus_evt & scl_rise & (bit_cnt_ff == 3'h7)
		& (state_ff == S_DEV || state_ff == S_ADR || state_ff == S_WR);
	assign adr_take = byte_done & (state_ff == S_ADR);
	assign wr_take = byte_done & (state_ff == S_WR) & ~i_write_control_pin;
	assign dev_match = (rx_byte[7:4] == DEV_TYPE_ID) && (rx_byte[3:1] == i_chip_sel);
	// next byte goes out on the closing fall of an acknowledged slot
	assign load_tx = ~bus_evt & scl_fall & nine_ff
		& ((state_ff == S_SACK && after_ff == S_RD) || (state_ff == S_MACK && ack_ff));
	assign tx_byte = (fifo_cnt_ff != 2'h0) ? fifo_ff[0].data : 8'hFF;

	// acknowledge decision for the byte just received
	always_comb begin
		nxt_ack = 1'b1;
		nxt_after = S_WR;
		dev_read = 1'b0;
		if (state_ff == S_DEV) begin
			nxt_ack = dev_match;
			nxt_after = !dev_match ? S_WAIT : (rx_byte[0] ? S_RD : S_ADR);
			dev_read = dev_match & rx_byte[0];
		end else if (state_ff == S_WR) begin
			nxt_ack = ~i_write_control_pin;
			nxt_after = i_write_control_pin ? S_WAIT : S_WR;
		end
	end

	// ************************************************************
	// protocol state machine
	// ************************************************************
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_ff <= S_IDLE;
			after_ff <= S_IDLE;
			bit_cnt_ff <= 3'h0;
			shreg_ff <= 8'h00;
			ack_ff <= 1'b0;
			nine_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			rd_mode_ff <= 1'b0;
			sda_out_ff <= 1'b0; // open drain: the pad only ever pulls low
		end else if (busy_ff) begin
			// interface shut down while programming
			state_ff <= S_IDLE;
			sda_oe_ff <= 1'b0;
			rd_mode_ff <= 1'b0;
		end else if (start_det) begin
			// a restart also lands here
			state_ff <= S_DEV;
			bit_cnt_ff <= 3'h0;
			sda_oe_ff <= 1'b0;
			rd_mode_ff <= 1'b0;
		end else if (stop_det) begin
			state_ff <= S_IDLE;
			sda_oe_ff <= 1'b0;
			rd_mode_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				S_IDLE, S_WAIT: begin
					sda_oe_ff <= 1'b0;
				end
				S_DEV, S_ADR, S_WR: begin
					if (scl_rise) begin
						shreg_ff <= rx_byte;
						bit_cnt_ff <= bit_cnt_ff + 3'h1;
						if (bit_cnt_ff == 3'h7) begin
							state_ff <= S_SACK;
							nine_ff <= 1'b0;
							ack_ff <= nxt_ack;
							after_ff <= nxt_after;
							rd_mode_ff <= dev_read;
						end
					end
				end
				S_SACK: begin
					if (scl_rise) begin
						nine_ff <= 1'b1;
					end else if (scl_fall && !nine_ff) begin
						sda_oe_ff <= ack_ff;
					end else if (scl_fall) begin
						state_ff <= after_ff;
						bit_cnt_ff <= 3'h0;
						shreg_ff <= {tx_byte[6:0], 1'b0};
						// open drain: only a zero is driven
						sda_oe_ff <= (after_ff == S_RD) ? ~tx_byte[7] : 1'b0;
					end
				end
				S_RD: begin
					if (scl_rise) begin
						bit_cnt_ff <= bit_cnt_ff + 3'h1;
						if (bit_cnt_ff == 3'h7) begin
							state_ff <= S_MACK;
							nine_ff <= 1'b0;
						end
					end else if (scl_fall) begin
						sda_oe_ff <= ~shreg_ff[7];
						shreg_ff <= {shreg_ff[6:0], 1'b0};
					end
				end
				S_MACK: begin
					if (scl_rise) begin
						nine_ff <= 1'b1;
						ack_ff <= ~i_sda;
					end else if (scl_fall && !nine_ff) begin
						sda_oe_ff <= 1'b0;
					end else if (scl_fall && ack_ff) begin
						state_ff <= S_RD;
						bit_cnt_ff <= 3'h0;
						shreg_ff <= {tx_byte[6:0], 1'b0};
						sda_oe_ff <= ~tx_byte[7];
					end else if (scl_fall) begin
						state_ff <= S_WAIT;
						sda_oe_ff <= 1'b0;
					end
				end
			endcase
		end
	end

	// ************************************************************
	// word address pointer
	// ************************************************************
	// writes roll over inside the sixteen-byte page
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			addr_ff <= 8'h00;
		end else if (adr_take) begin
			addr_ff <= rx_byte;
		end else if (wr_take) begin
			addr_ff <= {addr_ff[7:4], addr_ff[3:0] + 4'h1};
		end else if (load_tx && fifo_cnt_ff != 2'h0) begin
			addr_ff <= fifo_ff[0].addr + 8'h01;
		end
	end

	// ************************************************************
	// read prefetch buffer, two entries
	// ************************************************************
	// keeps the next byte ready so a slow store never stalls the bus
	assign fifo_flush = start_det | stop_det | adr_take | busy_ff;
	assign fifo_push = rd_mode_ff & (fifo_cnt_ff < 2'h2);
	assign fifo_pop = load_tx & (fifo_cnt_ff != 2'h0);
	assign fifo_in.addr = addr_ff + {6'h00, fifo_cnt_ff};
	assign fifo_in.data = mem_ff[fifo_in.addr];

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			fifo_cnt_ff <= 2'h0;
			fifo_ff[0] <= '0;
			fifo_ff[1] <= '0;
		end else if (fifo_flush) begin
			fifo_cnt_ff <= 2'h0;
		end else if (fifo_push && fifo_pop) begin
			fifo_ff[0] <= fifo_in;
		end else if (fifo_push) begin
			fifo_ff[fifo_cnt_ff[0]] <= fifo_in;
			fifo_cnt_ff <= fifo_cnt_ff + 2'h1;
		end else if (fifo_pop) begin
			fifo_ff[0] <= fifo_ff[1];
			fifo_cnt_ff <= fifo_cnt_ff - 2'h1;
		end
	end

	// ************************************************************
	// page latch
	// ************************************************************
	// a write without its stop is abandoned at the next start
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			page_base_ff <= 4'h0;
			page_mask_ff <= '0;
			for (int i = 0; i < PAGE_BYTES; i++) begin
				page_data_ff[i] <= 8'h00;
			end
		end else if (commit || (start_det && !busy_ff)) begin
			// a start during programming must not drop the pending page
			page_mask_ff <= '0;
		end else if (wr_take) begin
			page_base_ff <= addr_ff[7:4];
			page_data_ff[addr_ff[3:0]] <= rx_byte;
			page_mask_ff[addr_ff[3:0]] <= 1'b1;
		end
	end

	// ************************************************************
	// internal write cycle
	// ************************************************************
	assign commit = busy_ff & (wrc_cnt_ff == '0);

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			busy_ff <= 1'b0;
			wrc_cnt_ff <= '0;
		end else if (busy_ff) begin
			wrc_cnt_ff <= wrc_cnt_ff - CW'(1);
			busy_ff <= ~commit;
		end else if (stop_det && page_mask_ff != '0) begin
			busy_ff <= 1'b1;
			wrc_cnt_ff <= CW'(WRC_CYCLES - 1);
		end
	end

	// ************************************************************
	// byte store
	// ************************************************************
	// map is loaded on reset; a finished write lands at cycle end
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int i = 0; i < MEM_BYTES; i++) begin
				mem_ff[i] <= spd_default(8'(i));
			end
		end else if (commit) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (page_mask_ff[i]) begin
					mem_ff[{page_base_ff, 4'(i)}] <= page_data_ff[i];
				end
			end
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign o_sda_out = sda_out_ff;
	assign o_sda_oe = sda_oe_ff;
	assign o_write_busy = busy_ff;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking chk_cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	logic [CW:0] busy_age_ff;
	logic [7:0] chk_sum;

	// helper: cycles spent in one write cycle
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			busy_age_ff <= '0;
		end else begin
			busy_age_ff <= busy_ff ? busy_age_ff + (CW+1)'(1) : '0;
		end
	end

	// helper: running sum of the fixed header
	always_comb begin
		chk_sum = 8'h00;
		for (int i = 0; i < 63; i++) begin
			chk_sum = chk_sum + mem_ff[i];
		end
	end

	wrc_bound_a: assert property (busy_age_ff <= (CW+1)'(WRC_CYCLES))
		else $error("write cycle too long");
	wrc_start_a: assert property (stop_det && !busy_ff && page_mask_ff != '0 |=> busy_ff)
		else $error("write cycle not started by stop");
	busy_quiet_a: assert property (busy_ff |=> !sda_oe_ff && state_ff == S_IDLE)
		else $error("bus driven while programming");
	own_addr_ack_a: assert property (byte_done && state_ff == S_DEV && dev_match
		|=> state_ff == S_SACK && ack_ff ##[1:1000] (state_ff == S_SACK && sda_oe_ff))
		else $error("own address not acknowledged");
	wc_block_a: assert property (byte_done && state_ff == S_WR && i_write_control_pin
		|=> !ack_ff && after_ff == S_WAIT && page_mask_ff == $past(page_mask_ff))
		else $error("write taken with control pin high");
	page_fill_a: assert property (wr_take |=> page_mask_ff[$past(addr_ff[3:0])]
		&& addr_ff[7:4] == $past(addr_ff[7:4]))
		else $error("page byte not latched");
	rnd_addr_a: assert property (adr_take |=> addr_ff == $past(rx_byte) && fifo_cnt_ff == 2'h0)
		else $error("word address not loaded");
	seq_next_a: assert property (fifo_pop |=> addr_ff == $past(fifo_ff[0].addr) + 8'h01)
		else $error("sequential address not advanced");
	nack_end_a: assert property (state_ff == S_MACK && nine_ff && !ack_ff && scl_fall
		&& !bus_evt |=> state_ff == S_WAIT && !sda_oe_ff)
		else $error("sending went on after no acknowledge");
	hdr_bytes_a: assert property (!$past(i_nrst) |-> mem_ff[0] == 8'h80 && mem_ff[1] == 8'h08)
		else $error("size bytes wrong");
	type_rev_a: assert property (!$past(i_nrst) |-> mem_ff[2] == 8'h07 && mem_ff[62] == 8'h11)
		else $error("type or revision byte wrong");
	density_a: assert property (!$past(i_nrst) |-> mem_ff[3] == (LARGE_VARIANT ? 8'h0D : 8'h0C)
		&& mem_ff[12] == (LARGE_VARIANT ? 8'h82 : 8'h80) && mem_ff[31] == (LARGE_VARIANT ? 8'h40 : 8'h20))
		else $error("density bytes wrong");
	checksum_a: assert property (!$past(i_nrst) |-> mem_ff[63] == chk_sum
		&& chk_sum == (LARGE_VARIANT ? 8'h80 : 8'h5D))
		else $error("checksum byte wrong");
	burst_bank_a: assert property (!$past(i_nrst) |-> mem_ff[16] == 8'h0E
		&& mem_ff[17] == 8'h04 && mem_ff[18] == 8'h1C)
		else $error("burst, bank or latency byte wrong");
	cycle_time_a: assert property (!$past(i_nrst) |-> mem_ff[9] == 8'h50
		&& mem_ff[23] == 8'h60 && mem_ff[25] == 8'h75)
		else $error("cycle time bytes wrong");

	seq_read_c: cover property (fifo_pop ##[1:1000] fifo_pop);
	commit_c: cover property (commit);
	wc_nack_c: cover property (byte_done && state_ff == S_WR && i_write_control_pin);
	busy_nack_c: cover property (busy_ff && start_det);
endmodule // spdes_serial_access
`default_nettype wire

//--- core/spdes_pkg.sv
// package: constants, types and default byte map of the presence-detect store
//
// Behaviour
// - random read: restart, reselect reading, one byte
// - sequential read continues while master acknowledges
// - page write up to sixteen bytes, pin low
// - internal write cycle ends within 10 ms
// - busy writing: bus ignored, data line released
// - byte 0 reads 80, byte 1 reads 08
// - byte 2 reads 07, byte 62 reads 11
// - bytes 3, 12, 31 follow module density
// - byte 63 holds checksum of bytes 0-62
// - bytes 16-18 read 0E, 04, 1C
// - reserved bytes 36-40, 46, 48-61 read zero
// - byte 64 maker code, 65-71 continuation bytes
// - part number, build date, serial number fields
// - byte 9 reads 50, 23 60, 25 75
// - acknowledge own address and each written byte while pin low
// - no master acknowledge: stop sending, await stop
package spdes_pkg;
	// ************************************************************
	// bus framing and timing
	// ************************************************************
	localparam logic [3:0] DEV_TYPE_ID = 4'hA;
	localparam int unsigned SEL_BITS = 3;
	localparam int unsigned PAGE_BYTES = 16;
	localparam int unsigned MEM_BYTES = 256;
	localparam int unsigned WRC_TIME_MS = 10;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned WRC_CYCLES_DEF = WRC_TIME_MS * (CLK_HZ / 1000);
	// ************************************************************
	// byte offsets of the map
	// ************************************************************
	localparam logic [7:0] OFS_BYTES_USED_COUNT = 8'h00;
	localparam logic [7:0] OFS_TOTAL_STORAGE_SIZE = 8'h01;
	localparam logic [7:0] OFS_MEMORY_TYPE_CODE = 8'h02;
	localparam logic [7:0] OFS_ROW_ADDRESS_BITS = 8'h03;
	localparam logic [7:0] OFS_CYCLE_TIME_TOP_LATENCY = 8'h09;
	localparam logic [7:0] OFS_REFRESH_RATE_TYPE = 8'h0C;
	localparam logic [7:0] OFS_BURST_LENGTHS_SUPPORTED = 8'h10;
	localparam logic [7:0] OFS_INTERNAL_BANK_COUNT = 8'h11;
	localparam logic [7:0] OFS_READ_LATENCIES_SUPPORTED = 8'h12;
	localparam logic [7:0] OFS_CYCLE_TIME_MID = 8'h17;
	localparam logic [7:0] OFS_CYCLE_TIME_LOW = 8'h19;
	localparam logic [7:0] OFS_RANK_DENSITY = 8'h1F;
	localparam logic [7:0] OFS_SPEC_REVISION = 8'h3E;
	localparam logic [7:0] OFS_CHECKSUM_LOW_BYTES = 8'h3F;
	localparam logic [7:0] OFS_MAKER_CODE = 8'h40;
	localparam logic [7:0] OFS_MAKER_CONT_FIRST = 8'h41;
	localparam logic [7:0] OFS_MAKER_CONT_LAST = 8'h47;
	localparam logic [7:0] OFS_BUILD_LOCATION = 8'h48;
	localparam logic [7:0] OFS_PART_FIRST = 8'h49;
	localparam int unsigned PART_LEN = 18;
	localparam logic [7:0] OFS_PCB_ID = 8'h5B;
	localparam logic [7:0] OFS_BUILD_YEAR_BCD = 8'h5D;
	localparam logic [7:0] OFS_BUILD_WEEK_BCD = 8'h5E;
	localparam logic [7:0] OFS_SERIAL_FIRST = 8'h5F;
	localparam int unsigned SERIAL_LEN = 4;
	// reserved positions among bytes 0-63
	localparam logic [63:0] RSV_MASK = 64'h3FFF_41F0_0000_0000;
	// ************************************************************
	// fixed bytes 0-63, smaller variant
	// ************************************************************
	localparam logic [7:0] HDR_BYTES [64] = '{
		8'h80, 8'h08, 8'h07, 8'h0C, 8'h0A, 8'h01, 8'h40, 8'h00,
		8'h04, 8'h50, 8'h70, 8'h00, 8'h80, 8'h08, 8'h00, 8'h01,
		8'h0E, 8'h04, 8'h1C, 8'h01, 8'h02, 8'h20, 8'hC0, 8'h60,
		8'h70, 8'h75, 8'h75, 8'h3C, 8'h28, 8'h3C, 8'h28, 8'h20,
		8'h60, 8'h60, 8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h37, 8'h46, 8'h30, 8'h28, 8'h50, 8'h00, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h5D};
	// density-dependent bytes, larger variant
	localparam logic [7:0] ROW_BITS_LARGE = 8'h0D;
	localparam logic [7:0] REFRESH_LARGE = 8'h82;
	localparam logic [7:0] DENSITY_LARGE = 8'h40;
	localparam logic [7:0] CHECKSUM_LARGE = 8'h80;
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_DEV = 3'b001, S_ADR = 3'b010, S_WR = 3'b011,
		S_SACK = 3'b100, S_RD = 3'b101, S_MACK = 3'b110, S_WAIT = 3'b111
	} spdes_state_t;
	// one prefetched byte with the address it came from
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} spdes_rd_t;
endpackage

//--- test/spdes_bus_master.sv
// two-wire bus master model facing the presence-detect store
`timescale 1ns/1ps
`default_nettype none
module spdes_bus_master (
	// clock and open-drain bus
	input wire logic i_ref_clk,
	input wire logic i_sda,
	output logic o_scl = 1'b1,
	output logic o_sda_oe = 1'b0,
	// each byte or acknowledge bit seen on the wire
	output logic o_res_valid = 1'b0,
	output logic [7:0] o_res_val = 8'h00
);
	// ********
	// bus cycles
	// ********
	// changes land 1 ns after the edge, never on it
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	// scl low four cycles; sampled mid-high so the registered answer has settled
	task automatic bit_io(input logic b, output logic s);
		o_scl = 1'b0;
		tick(2);
		o_sda_oe = ~b;
		tick(2);
		o_scl = 1'b1;
		tick(2);
		s = i_sda;
		tick(2);
	endtask
	// 0: start or repeated start, 1: stop; data moves while scl is high
	task automatic cond(input logic p);
		o_scl = 1'b0;
		tick(2);
		o_sda_oe = p;
		tick(2);
		o_scl = 1'b1;
		tick(4);
		o_sda_oe = ~p;
		tick(4);
	endtask
	// byte out then slave acknowledge, or byte in then ours (low asks for more)
	task automatic xfer(input logic rd, input logic [7:0] d, input logic more);
		logic [7:0] v;
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(rd | d[i], v[i]);
		bit_io(rd ? ~more : 1'b1, s);
		o_res_val = rd ? v : {7'h00, s};
		o_res_valid = 1'b1;
		tick(1);
		o_res_valid = 1'b0;
	endtask
endmodule  // spdes_bus_master
`default_nettype wire

//--- test/spd_eeprom_serial_access_tb_top.sv
// self-checking bench of the presence-detect store serial slave
`timescale 1ns/1ps
`default_nettype none
module spd_eeprom_serial_access_tb_top;
	import spdes_pkg::*;
	// ********
	// set-up and expected store image
	// ********
	localparam int unsigned WRC = 200;
	localparam logic [2:0] SEL = 3'h5;
	localparam logic ACK = 1'b0;
	localparam logic NAK = 1'b1;
	localparam logic [7:0] WR_SEL = {DEV_TYPE_ID, SEL, 1'b0};
	localparam logic [7:0] RD_SEL = {DEV_TYPE_ID, SEL, 1'b1};
	localparam logic [143:0] PN = "MODULE-PART-NUMBER";
	localparam logic [15:0] FIX [31] = '{16'h0080, 16'h0108, 16'h0207, 16'h030C, 16'h040A, 16'h0501,
		16'h0640, 16'h0950, 16'h0C80, 16'h100E, 16'h1104, 16'h121C, 16'h1760, 16'h1975, 16'h1F20, 16'h3E11,
		16'h3F5D, 16'h405A, 16'h41A5, 16'h42A5, 16'h43A5, 16'h44A5, 16'h45A5, 16'h46A5, 16'h47A5, 16'h5D24,
		16'h5E01, 16'h5F12, 16'h6034, 16'h6156, 16'h6278};
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_write_control_pin = 1'b0;
	logic [2:0] chip_sel = SEL;
	logic scl, m_oe, sda_out, sda_oe, busy, res_valid;
	logic [7:0] res_val, d;
	logic [7:0] mem [256];
	logic known [256];
	logic [9:0] exp_q [$];
	int error_cnt = 0;
	int n_checks = 0;
	int busy_cnt = 0;
	int writes = 0;
	integer seed = 32'h5e90;
	// open-drain wire with pull-up
	wire logic sda = ~(m_oe | sda_oe);
	// 40 MHz reference
	always #12.5 i_ref_clk = ~i_ref_clk;
	// part number, year and serial are arbitrary; maker codes and week keep their defaults
	spdes_serial_access #(.PART_NUMBER(PN), .BUILD_YEAR(8'h24), .SERIAL_NUM(32'h12345678),
		.WRC_CYCLES(WRC)) spdes_serial_access_inst (
		.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
		.o_sda_oe(sda_oe), .i_chip_sel(chip_sel), .i_write_control_pin(i_write_control_pin), .o_write_busy(busy));
	spdes_bus_master spdes_bus_master_inst (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl),
		.o_sda_oe(m_oe), .o_res_valid(res_valid), .o_res_val(res_val));
	// image: zero where known blank, fixed bytes, part number text
	initial begin
		for (int a = 0; a < 256; a++) begin
			mem[a] = 8'h00;
			known[a] = a >= 99 || (a >= 36 && a <= 40) || a == 46 || (a >= 48 && a <= 61);
		end
		foreach (FIX[i]) begin
			mem[FIX[i][15:8]] = FIX[i][7:0];
			known[FIX[i][15:8]] = 1'b1;
		end
		for (int i = 0; i < 18; i++) begin
			mem[73 + i] = PN[143 - 8 * i -: 8];
			known[73 + i] = 1'b1;
		end
	end
	// ********
	// checks and bus sequences
	// ********
	task automatic tally(input logic ok, input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (!ok) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic check_byte(input logic [7:0] e, input logic [7:0] g);
		tally(g === e, "read byte", 32'(e), 32'(g));
	endtask
	task automatic check_ack(input logic e, input logic g);
		tally(g === e, "acknowledge", 32'(e), 32'(g));
	endtask
	task automatic check_count(input string nm, input int e, input int g);
		tally(g == e, nm, 32'(e), 32'(g));
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// bounded wait for the internal write cycle to end; a hang ends the run
	task automatic wait_idle();
		int n;
		for (n = 0; n < 2000 && busy !== 1'b0; n++)
			@(posedge i_ref_clk);
		#1;
		if (n == 2000) begin
			error_cnt++;
			final_report();
		end
	endtask
	// total cycles spent in internal write cycles
	always @(posedge i_ref_clk)
		if (busy === 1'b1)
			busy_cnt <= busy_cnt + 1;
	// oldest note against each result the master reports
	always @(posedge i_ref_clk)
		if (res_valid === 1'b1) begin
			logic [9:0] e;
			if (exp_q.size() == 0)
				check_count("unexpected result", 0, 1);
			else begin
				e = exp_q.pop_front();
				if (e[8])
					check_ack(e[0], res_val[0]);
				else if (e[9])
					check_byte(e[7:0], res_val);
			end
		end
	task automatic send(input logic [7:0] v, input logic a);
		exp_q.push_back({2'b11, 7'h00, a});
		spdes_bus_master_inst.xfer(1'b0, v, 1'b0);
	endtask
	// unknown bytes are read but not compared
	task automatic recv(input logic [7:0] a, input logic more);
		exp_q.push_back({known[a], 1'b0, mem[a]});
		spdes_bus_master_inst.xfer(1'b1, 8'h00, more);
	endtask
	task automatic point(input logic [7:0] a);
		spdes_bus_master_inst.cond(1'b0);
		send(WR_SEL, ACK);
		send(a, ACK);
	endtask
	// random read of n bytes, last one refused by the master
	task automatic rd_run(input logic [7:0] a, input int n);
		point(a);
		spdes_bus_master_inst.cond(1'b0);
		send(RD_SEL, ACK);
		for (int i = 0; i < n; i++)
			recv(a + 8'(i), i < n - 1);
		spdes_bus_master_inst.cond(1'b1);
	endtask
	// ********
	// main sequence
	// ********
	initial begin
		repeat (16) @(posedge i_ref_clk);
		#1;
		i_nrst = 1'b1;
		repeat (4) @(posedge i_ref_clk);
		#1;
		rd_run(8'h00, 128);
		rd_run(8'h3E, 1);
		$display("map test done");
		// seventeen bytes from mid-page: the last lands on the first
		point(8'hA3);
		for (int i = 0; i < 17; i++) begin
			d = 8'($random(seed));
			mem[{4'hA, 4'(3 + i)}] = d;
			known[{4'hA, 4'(3 + i)}] = 1'b1;
			send(d, ACK);
		end
		spdes_bus_master_inst.cond(1'b1);
		writes++;
		// a select while busy must go unanswered
		spdes_bus_master_inst.cond(1'b0);
		send(WR_SEL, NAK);
		spdes_bus_master_inst.cond(1'b1);
		wait_idle();
		check_count("busy cycles", writes * WRC, busy_cnt);
		rd_run(8'hA0, 16);
		$display("page write test done");
		// pin high: address taken, data refused, no write cycle
		i_write_control_pin = 1'b1;
		point(8'hA0);
		send(8'($random(seed)), NAK);
		spdes_bus_master_inst.cond(1'b1);
		i_write_control_pin = 1'b0;
		wait_idle();
		check_count("busy cycles", writes * WRC, busy_cnt);
		rd_run(8'hA0, 1);
		// byte write at the top, read back wrapping to byte 0
		d = 8'($random(seed));
		mem[8'hFF] = d;
		point(8'hFF);
		send(d, ACK);
		spdes_bus_master_inst.cond(1'b1);
		writes++;
		wait_idle();
		check_count("busy cycles", writes * WRC, busy_cnt);
		rd_run(8'hFF, 2);
		$display("write control test done");
		// foreign type code and foreign straps are refused
		spdes_bus_master_inst.cond(1'b0);
		send({4'h6, SEL, 1'b0}, NAK);
		chip_sel = SEL ^ (3'($random(seed)) | 3'h1);
		spdes_bus_master_inst.cond(1'b0);
		send(WR_SEL, NAK);
		spdes_bus_master_inst.cond(1'b1);
		chip_sel = SEL;
		tally(sda_out === 1'b0, "data out level", 32'h0, 32'(sda_out));
		$display("select test done");
		check_count("notes left", 0, exp_q.size());
		final_report();
	end
endmodule  // spd_eeprom_serial_access_tb_top
`default_nettype wire
